// file: core/bbd_consts.svh
`ifndef BBD_CONSTS_SVH
`define BBD_CONSTS_SVH

// register port geometry
`define BBD_AW           5
`define BBD_DW           16

// register byte offsets
`define BBD_OFF_IO_CFG   5'h00
`define BBD_OFF_MEM_CFG  5'h04
`define BBD_OFF_OPT_CFG  5'h08
`define BBD_OFF_STATUS   5'h0C
`define BBD_OFF_IO_CNT   5'h10
`define BBD_OFF_MEM_CNT  5'h14
`define BBD_OFF_LAST_LO  5'h18
`define BBD_OFF_LAST_HI  5'h1C

// reset values: port block at 50 hex, global memory, hidden by phantom
`define BBD_RST_IO_SW    4'hA
`define BBD_RST_MEM_SW   12'h000
`define BBD_RST_OPT      8'h60

// option register field positions
`define BBD_OPT_WAIT_LSB 0
`define BBD_OPT_DIS      4
`define BBD_OPT_XDIS     5
`define BBD_OPT_PHD      6
`define BBD_OPT_PHE      7

// status register field positions
`define BBD_ST_IO_HIT    0
`define BBD_ST_MEM_HIT   1
`define BBD_ST_CONFLICT  2
`define BBD_ST_READY     3
`define BBD_ST_REM_LSB   4

// address bit splitting the 4K block into two 2K sockets
`define BBD_SOCK_BIT     11
// largest wait-state count the switches can ask for
`define BBD_WAIT_MAX     8

`endif

// file: core/bbd_pkg.sv
package bbd_pkg;

   // one bus cycle as seen by the board
   typedef struct packed {
      logic        start;
      logic        stop;
      logic        io;
      logic        phantom_n;
      logic [23:0] addr;
   } bbd_cyc_t;

   // board select lines
   typedef struct packed {
      logic io;
      logic mem;
      logic sock_lo;
      logic sock_hi;
   } bbd_sel_t;

   // configuration switches, a 1 is a switch set to ON
   typedef struct packed {
      logic [3:0]  wait_sw;
      logic        memory_disable_option;
      logic        extended_decode_disable;
      logic        phantom_hides_memory;
      logic        phantom_shows_memory;
      logic [3:0]  io_sw;
      logic [11:0] mem_sw;
   } bbd_cfg_t;

   // ON needs a 0 on the line, OFF a 1; bits outside care always match
   function automatic logic bbd_sw_match(input logic [11:0] addr,
                                         input logic [11:0] sw,
                                         input logic [11:0] care);
      return &(~care | (addr ^ sw));
   endfunction

endpackage

// file: core/bbd_decode.sv
`timescale 1ns/100ps
`include "bbd_consts.svh"
module bbd_decode
   import bbd_pkg::*;
(
   input  wire bbd_cyc_t cyc,
   input  wire bbd_cfg_t cfg,
   output bbd_sel_t      sel,
   output logic          conflict
);
   logic io_hit;
   logic mem_addr_ok;
   logic phantom_ok;

   // port block compare on address bits 7..4 only
   assign io_hit = cyc.io & bbd_sw_match({8'h00, cyc.addr[7:4]}, {8'h00, cfg.io_sw}, 12'h00F);

   // global mode drops the page bits from the compare
   assign mem_addr_ok = bbd_sw_match(cyc.addr[23:12], cfg.mem_sw,
                                     cfg.extended_decode_disable ? 12'h00F : 12'hFFF);

   // both phantom options at once is illegal; memory stays off then
   assign conflict   = cfg.phantom_hides_memory & cfg.phantom_shows_memory;
   assign phantom_ok = conflict ? 1'b0 :
                       cfg.phantom_hides_memory ? cyc.phantom_n :
                       cfg.phantom_shows_memory ? ~cyc.phantom_n : 1'b1;

   // memory answers nothing while the disable option is on
   assign sel.io      = io_hit;
   assign sel.mem     = ~cyc.io & ~cfg.memory_disable_option & mem_addr_ok & phantom_ok;
   assign sel.sock_lo = sel.mem & ~cyc.addr[`BBD_SOCK_BIT];
   assign sel.sock_hi = sel.mem & cyc.addr[`BBD_SOCK_BIT];
endmodule

// file: core/bbd_wait.sv
`timescale 1ns/100ps
`include "bbd_consts.svh"
module bbd_wait #(
   parameter int WAIT_MAX = `BBD_WAIT_MAX
) (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       start,
   input  wire logic [3:0] wait_sw,
   output logic            ready,
   output logic [3:0]      remain
);
   // the counter and the decode below serve exactly eight waits
   if (WAIT_MAX != 8) begin : g_chk
      $error("bbd_wait: WAIT_MAX must be 8");
   end

   // highest ON position wins, so odd settings still give a sane count
   function automatic logic [3:0] wait_count(input logic [3:0] sw);
      casez (sw)
         4'b1???: return 4'h8;
         4'b01??: return 4'h4;
         4'b001?: return 4'h2;
         4'b0001: return 4'h1;
         default: return 4'h0;
      endcase
   endfunction

   // ready low for exactly the chosen count after a hit
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ready  <= 1'b1;
         remain <= 4'h0;
      end else if (start && wait_count(wait_sw) != 4'h0) begin
         ready  <= 1'b0;
         remain <= wait_count(wait_sw);
      end else if (remain == 4'h1) begin
         ready  <= 1'b1;
         remain <= 4'h0;
      end else if (remain != 4'h0) begin
         remain <= remain - 4'h1;
      end
   end
endmodule

// file: core/bbd_top.sv
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/100ps
`include "bbd_consts.svh"
// Operation
// - board claims one block of 16 ports on any 16-port boundary
// - port address bits 7..4 compared against four switches
// - switch ON needs a 0 on its line, OFF needs a 1
// - memory is one 4K region on any 4K boundary
// - address bits 15..12 compared against four switches
// - extended mode also matches bits 23..16, one of 256 pages
// - an option picks full 24-bit decode or lower bits only
// - memory can show only with phantom, or hide with phantom
// - disable option stops memory answering any memory cycle
// - one, two, four or eight wait states are selectable
// - global mode ignores top eight bits, block in every page
// - both phantom options off ignores phantom; both on is illegal
// - lower 2K picks one socket, upper 2K the other
// - wait states apply to port and memory cycles alike
module bbd_top
   import bbd_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              resetn,
   input  wire bbd_cyc_t          cyc,
   input  wire logic [`BBD_AW-1:0] reg_addr,
   input  wire logic [`BBD_DW-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic [`BBD_DW-1:0]     reg_rdata,
   output bbd_sel_t               sel,
   output logic                   bus_ready,
   output logic                   cfg_conflict
);

   // configuration store
   logic [3:0]         io_sw;
   logic [11:0]        mem_sw;
   logic [7:0]         opt;
   bbd_cfg_t           cfg;

   // decode results for the cycle on the bus now
   bbd_sel_t           next_sel;
   logic               next_conflict;
   logic               board_hit;

   // wait-state engine
   logic [3:0]         wait_remain;

   // software-visible history
   logic               io_seen;
   logic               mem_seen;
   logic [`BBD_DW-1:0] io_count;
   logic [`BBD_DW-1:0] mem_count;
   logic [23:0]        last_addr;

   // register port strobes per register
   logic               wr_io;
   logic               wr_mem;
   logic               wr_opt;
   logic               wr_status;
   logic               wr_io_cnt;
   logic               wr_mem_cnt;

   assign wr_io      = reg_wr && reg_addr == `BBD_OFF_IO_CFG;
   assign wr_mem     = reg_wr && reg_addr == `BBD_OFF_MEM_CFG;
   assign wr_opt     = reg_wr && reg_addr == `BBD_OFF_OPT_CFG;
   assign wr_status  = reg_wr && reg_addr == `BBD_OFF_STATUS;
   assign wr_io_cnt  = reg_wr && reg_addr == `BBD_OFF_IO_CNT;
   assign wr_mem_cnt = reg_wr && reg_addr == `BBD_OFF_MEM_CNT;

   // switch image gathered into one carrier for the decoder
   always_comb begin
      cfg.wait_sw                 = opt[`BBD_OPT_WAIT_LSB +: 4];
      cfg.memory_disable_option   = opt[`BBD_OPT_DIS];
      cfg.extended_decode_disable = opt[`BBD_OPT_XDIS];
      cfg.phantom_hides_memory    = opt[`BBD_OPT_PHD];
      cfg.phantom_shows_memory    = opt[`BBD_OPT_PHE];
      cfg.io_sw                   = io_sw;
      cfg.mem_sw                  = mem_sw;
   end

   // port block switches; reset lands on the block software expects
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         io_sw <= `BBD_RST_IO_SW;
      end else if (wr_io) begin
         io_sw <= reg_wdata[3:0];
      end
   end

   // memory block switches: 15..12 in the low nibble, 23..16 above
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mem_sw <= `BBD_RST_MEM_SW;
      end else if (wr_mem) begin
         mem_sw <= reg_wdata[11:0];
      end
   end

   // option switches: waits, disable, global, phantom polarity
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         opt <= `BBD_RST_OPT;
      end else if (wr_opt) begin
         opt <= reg_wdata[7:0];
      end
   end

   // address compare for the cycle being offered
   bbd_decode u_decode (
      .cyc      (cyc),
      .cfg      (cfg),
      .sel      (next_sel),
      .conflict (next_conflict)
   );

   // either kind of hit stretches the cycle
   assign board_hit = cyc.start && (next_sel.io || next_sel.mem);

   bbd_wait #(
      .WAIT_MAX (`BBD_WAIT_MAX)
   ) u_wait (
      .clk     (clk),
      .resetn  (resetn),
      .start   (board_hit),
      .wait_sw (cfg.wait_sw),
      .ready   (bus_ready),
      .remain  (wait_remain)
   );

   // selects latched at cycle start, held to the cycle's end;
   // a start beside a stop belongs to the new cycle, so it wins
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sel <= '0;
      end else if (cyc.start) begin
         sel <= next_sel;
      end else if (cyc.stop) begin
         sel <= '0;
      end
   end

   // illegal phantom setting shown on a pin as well as in status
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cfg_conflict <= 1'b0;
      end else begin
         cfg_conflict <= next_conflict;
      end
   end

   // sticky hit flags; a hit in the clearing cycle survives
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         io_seen  <= 1'b0;
         mem_seen <= 1'b0;
      end else begin
         if (board_hit && next_sel.io) begin
            io_seen <= 1'b1;
         end else if (wr_status && reg_wdata[`BBD_ST_IO_HIT]) begin
            io_seen <= 1'b0;
         end
         if (board_hit && next_sel.mem) begin
            mem_seen <= 1'b1;
         end else if (wr_status && reg_wdata[`BBD_ST_MEM_HIT]) begin
            mem_seen <= 1'b0;
         end
      end
   end

   // access counters; they wrap, software takes differences
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         io_count <= '0;
      end else if (board_hit && next_sel.io) begin
         io_count <= io_count + `BBD_DW'(1);
      end else if (wr_io_cnt) begin
         io_count <= '0;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mem_count <= '0;
      end else if (board_hit && next_sel.mem) begin
         mem_count <= mem_count + `BBD_DW'(1);
      end else if (wr_mem_cnt) begin
         mem_count <= '0;
      end
   end

   // address of the latest cycle the board claimed
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         last_addr <= '0;
      end else if (board_hit) begin
         last_addr <= cyc.addr;
      end
   end

   // read data registered, valid only the cycle after the strobe;
   // unmapped offsets read zero so a stray read is harmless
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         case (reg_addr)
            `BBD_OFF_IO_CFG: begin
               reg_rdata <= {12'h000, io_sw};
            end
            `BBD_OFF_MEM_CFG: begin
               reg_rdata <= {4'h0, mem_sw};
            end
            `BBD_OFF_OPT_CFG: begin
               reg_rdata <= {8'h00, opt};
            end
            `BBD_OFF_STATUS: begin
               reg_rdata <= {8'h00, wait_remain, bus_ready, cfg_conflict, mem_seen, io_seen};
            end
            `BBD_OFF_IO_CNT: begin
               reg_rdata <= io_count;
            end
            `BBD_OFF_MEM_CNT: begin
               reg_rdata <= mem_count;
            end
            `BBD_OFF_LAST_LO: begin
               reg_rdata <= last_addr[15:0];
            end
            `BBD_OFF_LAST_HI: begin
               reg_rdata <= {8'h00, last_addr[23:16]};
            end
            default: begin
               reg_rdata <= '0;
            end
         endcase
      end else begin
         reg_rdata <= '0;
      end
   end

endmodule

// file: verif/bbd_monitor.sv
`timescale 1ns/100ps
`include "bbd_consts.svh"
module bbd_monitor
   import bbd_pkg::*;
(
   input wire logic               clk,
   input wire logic               resetn,
   input wire bbd_cyc_t           cyc,
   input wire logic [`BBD_AW-1:0] reg_addr,
   input wire logic [`BBD_DW-1:0] reg_wdata,
   input wire logic               reg_wr,
   input wire logic               reg_rd,
   input wire logic [`BBD_DW-1:0] reg_rdata,
   input wire bbd_sel_t           sel,
   input wire logic               bus_ready,
   input wire logic               cfg_conflict
);
   logic [3:0]  io_sh;
   logic [11:0] mem_sh;
   logic [7:0]  opt_sh;
   logic [3:0]  nw, expw, lowc;
   logic        io_hit, mem_hit, sock_hit, ph_ok;

   // shadow of the switch registers, kept from the write strobes
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         io_sh  <= `BBD_RST_IO_SW;
         mem_sh <= `BBD_RST_MEM_SW;
         opt_sh <= `BBD_RST_OPT;
      end else if (reg_wr) begin
         if (reg_addr == `BBD_OFF_IO_CFG) io_sh <= reg_wdata[3:0];
         if (reg_addr == `BBD_OFF_MEM_CFG) mem_sh <= reg_wdata[11:0];
         if (reg_addr == `BBD_OFF_OPT_CFG) opt_sh <= reg_wdata[7:0];
      end
   end

   // expected decode; a switch ON asks for a 0 on its line
   assign ph_ok    = opt_sh[6] ? (!opt_sh[7] && cyc.phantom_n) : (!opt_sh[7] || !cyc.phantom_n);
   assign io_hit   = cyc.io && cyc.addr[7:4] == ~io_sh;
   assign mem_hit  = !cyc.io && !opt_sh[4] && ph_ok && cyc.addr[15:12] == ~mem_sh[3:0]
                     && (opt_sh[5] || cyc.addr[23:16] == ~mem_sh[11:4]);
   assign sock_hit = mem_hit && cyc.addr[`BBD_SOCK_BIT];
   assign nw       = opt_sh[3] ? 4'h8 : opt_sh[2] ? 4'h4 : opt_sh[1] ? 4'h2 : {3'h0, opt_sh[0]};

   // waits owed by the cycle in flight; a new start restarts the tally
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         expw <= 4'h0;
         lowc <= 4'h0;
      end else if (cyc.start) begin
         expw <= (io_hit || mem_hit) ? nw : 4'h0;
         lowc <= 4'h0;
      end else if (!bus_ready) begin
         lowc <= lowc + 4'h1;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   io_sel_a: assert property (cyc.start |=> sel.io == $past(io_hit))
      else $error("port select wrong");
   mem_sel_a: assert property (cyc.start |=> sel.mem == $past(mem_hit))
      else $error("memory select wrong");
   sock_sel_a: assert property (cyc.start |=> sel.sock_hi == $past(sock_hit) && sel.sock_lo ==
      ($past(mem_hit) && !$past(sock_hit))) else $error("socket select wrong");
   wait_len_a: assert property ($rose(bus_ready) |-> lowc == expw)
      else $error("wait length wrong");
   wait_go_a: assert property (cyc.start && (io_hit || mem_hit) && nw != 4'h0 |=> !bus_ready)
      else $error("ready not dropped");
   no_wait_a: assert property (cyc.start && !io_hit && !mem_hit && bus_ready |=> bus_ready)
      else $error("miss stalled bus");
   ready_bound_a: assert property (!bus_ready |-> lowc < 4'h9)
      else $error("ready held too long");
   stop_clr_a: assert property (cyc.stop && !cyc.start |=> sel == '0)
      else $error("select kept after stop");
   conflict_flag_a: assert property (cfg_conflict == ($past(opt_sh[7]) && $past(opt_sh[6])))
      else $error("conflict flag wrong");
   opt_read_a: assert property (reg_rd && reg_addr == `BBD_OFF_OPT_CFG |=> reg_rdata == {8'h00, $past(opt_sh)})
      else $error("option readback wrong");

   cover property (cyc.start && io_hit);
   cover property (cyc.start && mem_hit);
   cover property ($rose(bus_ready) && expw == 4'h8);
endmodule

bind bbd_top bbd_monitor bbd_monitor_i (.clk, .resetn, .cyc, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata, .sel, .bus_ready, .cfg_conflict);

// file: verif/bbd_cpu_model.sv
`timescale 1ns/100ps
module bbd_cpu_model
   import bbd_pkg::*;
(
   input  wire logic clk,
   input  wire logic bus_ready,
   output bbd_cyc_t  cyc
);
   // idle bus at time zero, phantom line pulled up
   initial cyc = '{1'b0, 1'b0, 1'b0, 1'b1, 24'h000000};

   // start pulse with address, then wait for ready under a bound
   task automatic access(input logic io, input logic phn, input logic [23:0] a, output int w);
      @(posedge clk);
      cyc.start     <= 1'b1;
      cyc.io        <= io;
      cyc.phantom_n <= phn;
      cyc.addr      <= a;
      @(posedge clk);
      cyc.start <= 1'b0;
      w = 0;
      @(posedge clk);
      while (!bus_ready && w < 20) begin
         w++;
         @(posedge clk);
      end
   endtask

   // end the cycle after g idle edges; released lines lose the old value
   task automatic finish(input int g);
      repeat (g) @(posedge clk);
      cyc.stop      <= 1'b1;
      cyc.phantom_n <= 1'b1;
      cyc.addr      <= ~cyc.addr;
      @(posedge clk);
      cyc.stop <= 1'b0;
   endtask
endmodule

// file: verif/test_bus_board_address_decode.sv
`timescale 1ns/100ps
`include "bbd_consts.svh"
module test_bus_board_address_decode
   import bbd_pkg::*;
();
   typedef struct {
      logic [3:0]  iosw;
      logic [11:0] msw;
      logic [7:0]  opt;
      logic        io;
      logic        phn;
      logic [23:0] a;
      logic [3:0]  s;
      int          w;
   } bbd_row_t;

   logic               clk = 1'b0;
   logic               resetn = 1'b0;
   logic [`BBD_AW-1:0] reg_addr = '0;
   logic [`BBD_DW-1:0] reg_wdata = '0;
   logic               reg_wr = 1'b0;
   logic               reg_rd = 1'b0;
   logic [`BBD_DW-1:0] reg_rdata;
   logic [`BBD_DW-1:0] d;
   bbd_cyc_t           cyc;
   bbd_sel_t           sel;
   logic               bus_ready;
   logic               cfg_conflict;
   int                 err_total = 0;
   int                 n_checks = 0;
   int                 w;

   // switches, cycle, expected {io,mem,lo,hi} and waits
   bbd_row_t rows [14] = '{
      '{4'hA, 12'h000, 8'h60, 1'b1, 1'b1, 24'h000055, 4'h8, 0},
      '{4'hA, 12'h000, 8'h61, 1'b1, 1'b1, 24'h00005F, 4'h8, 1},
      '{4'hA, 12'h000, 8'h63, 1'b1, 1'b1, 24'h000065, 4'h0, 0},
      '{4'h0, 12'h000, 8'h64, 1'b1, 1'b1, 24'h0000F3, 4'h8, 4},
      '{4'h0, 12'h000, 8'h64, 1'b1, 1'b1, 24'h000073, 4'h0, 0},
      '{4'hA, 12'h000, 8'h6F, 1'b0, 1'b1, 24'h12F100, 4'h6, 8},
      '{4'hA, 12'h003, 8'h60, 1'b0, 1'b1, 24'h00C800, 4'h5, 0},
      '{4'hA, 12'hFE3, 8'h40, 1'b0, 1'b1, 24'h01C000, 4'h6, 0},
      '{4'hA, 12'hFE3, 8'h40, 1'b0, 1'b1, 24'h02C000, 4'h0, 0},
      '{4'hA, 12'h003, 8'h60, 1'b0, 1'b0, 24'h00C000, 4'h0, 0},
      '{4'hA, 12'h003, 8'hA0, 1'b0, 1'b0, 24'h00C000, 4'h6, 0},
      '{4'hA, 12'h003, 8'h20, 1'b0, 1'b0, 24'h00C000, 4'h6, 0},
      '{4'hA, 12'h003, 8'hE0, 1'b0, 1'b1, 24'h00C000, 4'h0, 0},
      '{4'hA, 12'h003, 8'h70, 1'b0, 1'b1, 24'h00C000, 4'h0, 0}
   };

   always #20 clk = ~clk;

   bbd_top bbd_top_i (.clk, .resetn, .cyc, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sel,
      .bus_ready, .cfg_conflict);
   bbd_cpu_model bbd_cpu_model_i (.clk, .bus_ready, .cyc);

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // one-cycle strobes launched just after an edge
   task automatic wr(input logic [4:0] a, input logic [15:0] v);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [4:0] a);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      d = reg_rdata;
   endtask

   initial begin
      repeat (20) @(posedge clk);
      chk("ready in reset", bus_ready, 1'b1);
      chk("sel in reset", sel, 4'h0);
      resetn <= 1'b1;
      rd(`BBD_OFF_OPT_CFG);
      chk("option reset", d, 16'h0060);
      rd(`BBD_OFF_IO_CFG);
      chk("port switch reset", d, 16'h000A);
      rd(5'h02);
      chk("unmapped read", d, 16'h0000);
      foreach (rows[i]) begin
         wr(`BBD_OFF_IO_CFG, {12'h000, rows[i].iosw});
         wr(`BBD_OFF_MEM_CFG, {4'h0, rows[i].msw});
         wr(`BBD_OFF_OPT_CFG, {8'h00, rows[i].opt});
         bbd_cpu_model_i.access(rows[i].io, rows[i].phn, rows[i].a, w);
         chk("select lines", sel, rows[i].s);
         chk("wait states", w, rows[i].w);
         if (w >= 20) end_sim();
         bbd_cpu_model_i.finish(i % 3);
      end
      // history after the table: three port hits, five memory hits
      rd(`BBD_OFF_IO_CNT);
      chk("port hit count", d, 16'h0003);
      rd(`BBD_OFF_MEM_CNT);
      chk("memory hit count", d, 16'h0005);
      rd(`BBD_OFF_LAST_LO);
      chk("last address", d, 16'hC000);
      rd(`BBD_OFF_STATUS);
      chk("status", d, 16'h000B);
      // write one clears both sticky flags, ready bit stays
      wr(`BBD_OFF_STATUS, 16'h0003);
      rd(`BBD_OFF_STATUS);
      chk("status cleared", d, 16'h0008);
      // both phantom options flag a conflict once the write lands
      wr(`BBD_OFF_OPT_CFG, 16'h00E0);
      repeat (2) @(posedge clk);
      chk("conflict", cfg_conflict, 1'b1);
      // reset in mid-run brings the switches back
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      chk("conflict in reset", cfg_conflict, 1'b0);
      resetn <= 1'b1;
      rd(`BBD_OFF_OPT_CFG);
      chk("option after reset", d, 16'h0060);
      end_sim();
   end
endmodule
